// [hdl/pstsel_pkg.sv]
/*
 * Package of the position segment trigger and select block: register map, field
 * layouts, reset values, terminal function codes, status codes and the state types.
 * Assumes a 32-bit AHB-Lite register bus and a 25 MHz system clock.
 */
package pstsel_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int PSTSEL_NTERM = 8;                 // Number of digital input terminals.
  localparam int PSTSEL_NSEL = 5;                  // Number of segment select bits.

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [11:0] PSTSEL_CMD_ADDR = 12'h898;
  localparam logic [11:0] PSTSEL_CTRL_ADDR = 12'h900;
  localparam logic [11:0] PSTSEL_STATE_ADDR = 12'h904;
  localparam logic [11:0] PSTSEL_IRQ_STAT_ADDR = 12'h908;
  localparam logic [11:0] PSTSEL_IRQ_EN_ADDR = 12'h90c;
  localparam logic [11:0] PSTSEL_IRQ_CLR_ADDR = 12'h910;
  localparam logic [11:0] PSTSEL_TERM_BASE_ADDR = 12'h920;
  localparam logic [11:0] PSTSEL_TERM_LAST_ADDR = 12'h93c;

  // ****************************************************************
  // Values of the segment command register
  // ****************************************************************
  localparam logic [15:0] PSTSEL_CMD_RESET = 16'h2710;    // Reads as running, segment 0.
  localparam logic [15:0] PSTSEL_CMD_RUN_BASE = 16'h2710; // Running code base.
  localparam logic [15:0] PSTSEL_CMD_DONE_BASE = 16'h4e20; // Completed code base.
  localparam logic [15:0] PSTSEL_CMD_STOP = 16'h03e8;     // Stop code.
  localparam logic [15:0] PSTSEL_CMD_SEG_MIN = 16'h0001;
  localparam logic [15:0] PSTSEL_CMD_SEG_MAX = 16'h001f;

  // ****************************************************************
  // Control word address of a segment
  // ****************************************************************
  localparam logic [15:0] PSTSEL_CW_BASE = 16'h0804;
  localparam int PSTSEL_CW_SHIFT = 2;              // Four addresses per segment.

  // ****************************************************************
  // Terminal function codes
  // ****************************************************************
  localparam logic [7:0] PSTSEL_FC_TRIG = 8'h16;
  localparam logic [7:0] PSTSEL_FC_SEL0 = 8'h17;   // Select bits follow in ascending order.
  localparam logic [7:0] PSTSEL_FC_STOP = 8'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PSTSEL_CTRL_SRC_BIT = 0;          // Internal command source selected.
  localparam int PSTSEL_STATE_RUN_BIT = 0;
  localparam int PSTSEL_STATE_SERVO_BIT = 1;
  localparam int PSTSEL_STATE_SEG_LSB = 8;
  localparam int PSTSEL_EV_START = 0;
  localparam int PSTSEL_EV_DONE = 1;
  localparam int PSTSEL_EV_STOP = 2;
  localparam int PSTSEL_EV_INVALID = 3;
  localparam int PSTSEL_NEV = 4;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [0:0] {
    PSTSEL_SEG_DONE = 1'b0,
    PSTSEL_SEG_RUN = 1'b1
  } pstsel_seg_state_t;

  typedef struct packed {
    logic [4:0] number;
    logic start;
    logic home;
    logic stop;
    logic [15:0] cw_addr;
  } pstsel_seg_cmd_t;

  typedef struct packed {
    logic [PSTSEL_NTERM-1:0] sync1;
    logic [PSTSEL_NTERM-1:0] sync2;
    logic trig_prev;
    logic stop_prev;
    logic [PSTSEL_NTERM-1:0][7:0] term_func;
    logic src_internal;
    pstsel_seg_state_t seg_state;
    logic [15:0] cmd_status;
    pstsel_seg_cmd_t cmd;
    logic [PSTSEL_NEV-1:0] irq_stat;
    logic [PSTSEL_NEV-1:0] irq_en;
    logic irq;
    logic [11:0] addr;
    logic wr_pend;
    logic rd_pend;
    logic [31:0] hrdata;
    logic hreadyout;
  } pstsel_state_t;

endpackage

// [hdl/pstsel_top.sv]
/*
 * Position segment trigger, select and stop logic with its AHB-Lite register slave.
 * Assumes terminals arrive asynchronously from pins, servo_en and seg_done come from
 * the motion core on the same clock, and the motion core follows the segment command.
 */
// The implementer's own choice: the AHB-Lite register port.
// Overview of operation
// - Five select bits form segment number 0..31.
// - Trigger rising edge starts the selected segment.
// - Segment zero launches home return, others normal.
// - Stop rising edge halts the running segment.
// - Terminals take roles by function code.
// - Writing 1..31 triggers; other values except 1000 only flag an invalid event.
// - Writing 1000 stops the running segment.
// - While running, command reads 10000 plus segment.
// - After completion, command reads 20000 plus segment.
// - Servo disabled: reads 20000, no point runs.
// - Written segments need internal source and servo.
// - Command register is 16 bits, resets 10000.
// - Control word address is base plus four per segment.
`timescale 1ns/100ps

module pstsel_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [pstsel_pkg::PSTSEL_NTERM-1:0] digital_input_terminal,
  input wire logic servo_en,
  input wire logic seg_done,
  output pstsel_pkg::pstsel_seg_cmd_t seg_cmd,
  output logic irq
);

  pstsel_pkg::pstsel_state_t r;
  pstsel_pkg::pstsel_state_t next_r;

  // ****************************************************************
  // Terminal role decode
  // ****************************************************************

  logic [pstsel_pkg::PSTSEL_NTERM-1:0] trig_hit;
  logic [pstsel_pkg::PSTSEL_NTERM-1:0] stop_hit;
  logic [pstsel_pkg::PSTSEL_NTERM-1:0][pstsel_pkg::PSTSEL_NSEL-1:0] sel_hit;

  // Each terminal drives the role whose code its function register holds.
  genvar gi;
  genvar gk;
  generate
    for (gi = 0; gi < pstsel_pkg::PSTSEL_NTERM; gi++) begin : g_term
      assign trig_hit[gi] = r.sync2[gi] &&
        (r.term_func[gi] == pstsel_pkg::PSTSEL_FC_TRIG);
      assign stop_hit[gi] = r.sync2[gi] &&
        (r.term_func[gi] == pstsel_pkg::PSTSEL_FC_STOP);
      for (gk = 0; gk < pstsel_pkg::PSTSEL_NSEL; gk++) begin : g_sel
        assign sel_hit[gi][gk] = r.sync2[gi] &&
          (r.term_func[gi] == pstsel_pkg::PSTSEL_FC_SEL0 + 8'(gk));
      end
    end
  endgenerate

  logic trig_lvl;
  logic stop_lvl;
  logic [4:0] sel_num;

  // Collapse the per-terminal matches into role levels and the select number.
  always_comb begin
    trig_lvl = |trig_hit;
    stop_lvl = |stop_hit;
    sel_num = '0;
    for (int i = 0; i < pstsel_pkg::PSTSEL_NTERM; i++) begin
      sel_num = sel_num | sel_hit[i];
    end
  end

  // ****************************************************************
  // Register read mux
  // ****************************************************************

  // Returns the word seen by software at a byte address; unmapped reads give zero.
  function automatic logic [31:0] read_word(input pstsel_pkg::pstsel_state_t s,
                                            input logic [11:0] a);
    logic [31:0] w;
    w = '0;
    if (a == pstsel_pkg::PSTSEL_CMD_ADDR) begin
      w[15:0] = s.cmd_status;
    end else if (a == pstsel_pkg::PSTSEL_CTRL_ADDR) begin
      w[pstsel_pkg::PSTSEL_CTRL_SRC_BIT] = s.src_internal;
    end else if (a == pstsel_pkg::PSTSEL_STATE_ADDR) begin
      w[pstsel_pkg::PSTSEL_STATE_RUN_BIT] = (s.seg_state == pstsel_pkg::PSTSEL_SEG_RUN);
      w[pstsel_pkg::PSTSEL_STATE_SERVO_BIT] = servo_en;
      w[pstsel_pkg::PSTSEL_STATE_SEG_LSB +: 5] = s.cmd.number;
    end else if (a == pstsel_pkg::PSTSEL_IRQ_STAT_ADDR) begin
      w[pstsel_pkg::PSTSEL_NEV-1:0] = s.irq_stat;
    end else if (a == pstsel_pkg::PSTSEL_IRQ_EN_ADDR) begin
      w[pstsel_pkg::PSTSEL_NEV-1:0] = s.irq_en;
    end else if (a >= pstsel_pkg::PSTSEL_TERM_BASE_ADDR &&
                 a <= pstsel_pkg::PSTSEL_TERM_LAST_ADDR && a[1:0] == 2'h0) begin
      w[7:0] = s.term_func[a[4:2]];
    end
    return w;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************

  logic wr_cmd;
  logic [15:0] wval;
  logic trig_edge;
  logic stop_edge;
  logic comm_ok;
  logic comm_seg;
  logic comm_stop;
  logic do_start;
  logic do_stop;
  logic [4:0] start_num;
  logic [pstsel_pkg::PSTSEL_NEV-1:0] ev;
  logic [pstsel_pkg::PSTSEL_NEV-1:0] clr;

  // Bus decode, segment sequencing, status code and interrupt bookkeeping.
  always_comb begin
    next_r = r;
    next_r.cmd.start = 1'b0;
    next_r.cmd.stop = 1'b0;
    ev = '0;
    clr = '0;
    wval = hwdata[15:0];

    // Two-flop synchroniser, then registered levels for edge detection.
    next_r.sync1 = digital_input_terminal;
    next_r.sync2 = r.sync1;
    next_r.trig_prev = trig_lvl;
    next_r.stop_prev = stop_lvl;
    trig_edge = trig_lvl && !r.trig_prev;
    stop_edge = stop_lvl && !r.stop_prev;

    // Write data phase: store plain registers, flag the command write.
    wr_cmd = r.wr_pend && (r.addr == pstsel_pkg::PSTSEL_CMD_ADDR);
    if (r.wr_pend) begin
      if (r.addr == pstsel_pkg::PSTSEL_CTRL_ADDR) begin
        next_r.src_internal = hwdata[pstsel_pkg::PSTSEL_CTRL_SRC_BIT];
      end else if (r.addr == pstsel_pkg::PSTSEL_IRQ_EN_ADDR) begin
        next_r.irq_en = hwdata[pstsel_pkg::PSTSEL_NEV-1:0];
      end else if (r.addr == pstsel_pkg::PSTSEL_IRQ_CLR_ADDR) begin
        clr = hwdata[pstsel_pkg::PSTSEL_NEV-1:0];
      end else if (r.addr >= pstsel_pkg::PSTSEL_TERM_BASE_ADDR &&
                   r.addr <= pstsel_pkg::PSTSEL_TERM_LAST_ADDR && r.addr[1:0] == 2'h0) begin
        next_r.term_func[r.addr[4:2]] = hwdata[7:0];
      end
    end

    // Classify a command write; only a live internal source may act on it.
    comm_ok = servo_en && r.src_internal;
    comm_seg = wr_cmd && wval >= pstsel_pkg::PSTSEL_CMD_SEG_MIN &&
      wval <= pstsel_pkg::PSTSEL_CMD_SEG_MAX;
    comm_stop = wr_cmd && wval == pstsel_pkg::PSTSEL_CMD_STOP;
    if (wr_cmd && !comm_seg && !comm_stop) begin
      ev[pstsel_pkg::PSTSEL_EV_INVALID] = 1'b1;
    end

    // A disabled servo runs nothing, from either path.
    do_stop = servo_en && (stop_edge || (comm_stop && comm_ok));
    do_start = servo_en && (trig_edge || (comm_seg && comm_ok));
    start_num = (comm_seg && comm_ok) ? wval[4:0] : sel_num;

    // Stop outranks a start in the same cycle.
    if (!servo_en) begin
      next_r.seg_state = pstsel_pkg::PSTSEL_SEG_DONE;
      next_r.cmd_status = pstsel_pkg::PSTSEL_CMD_DONE_BASE;
    end else if (do_stop) begin
      next_r.cmd.stop = 1'b1;
      next_r.seg_state = pstsel_pkg::PSTSEL_SEG_DONE;
      next_r.cmd_status = pstsel_pkg::PSTSEL_CMD_DONE_BASE + {11'h000, r.cmd.number};
      ev[pstsel_pkg::PSTSEL_EV_STOP] = 1'b1;
      ev[pstsel_pkg::PSTSEL_EV_DONE] = (r.seg_state == pstsel_pkg::PSTSEL_SEG_RUN);
    end else if (do_start) begin
      next_r.cmd.start = 1'b1;
      next_r.cmd.number = start_num;
      next_r.cmd.home = (start_num == 5'h00);
      next_r.cmd.cw_addr = pstsel_pkg::PSTSEL_CW_BASE +
        {9'h000, start_num, 2'h0};
      next_r.seg_state = pstsel_pkg::PSTSEL_SEG_RUN;
      next_r.cmd_status = pstsel_pkg::PSTSEL_CMD_RUN_BASE + {11'h000, start_num};
      ev[pstsel_pkg::PSTSEL_EV_START] = 1'b1;
    end else begin
      unique case (r.seg_state)
        pstsel_pkg::PSTSEL_SEG_RUN: begin
          if (seg_done) begin
            next_r.seg_state = pstsel_pkg::PSTSEL_SEG_DONE;
            next_r.cmd_status = pstsel_pkg::PSTSEL_CMD_DONE_BASE +
              {11'h000, r.cmd.number};
            ev[pstsel_pkg::PSTSEL_EV_DONE] = 1'b1;
          end
        end
        pstsel_pkg::PSTSEL_SEG_DONE: begin
          next_r.seg_state = pstsel_pkg::PSTSEL_SEG_DONE;
        end
      endcase
    end

    // Sticky events; a new event wins over a clear in the same cycle.
    next_r.irq_stat = (r.irq_stat & ~clr) | ev;
    next_r.irq = |(next_r.irq_stat & next_r.irq_en);

    // Bus: reads take one wait state so that a preceding write is already visible.
    if (r.rd_pend) begin
      next_r.hrdata = read_word(r, r.addr);
      next_r.hreadyout = 1'b1;
      next_r.rd_pend = 1'b0;
    end
    next_r.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_r.addr = haddr[11:0];
      if (hwrite) begin
        next_r.wr_pend = 1'b1;
      end else begin
        next_r.rd_pend = 1'b1;
        next_r.hreadyout = 1'b0;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Synchronous reset loads constants only.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= '0;
      r.cmd_status <= pstsel_pkg::PSTSEL_CMD_RESET;
      r.seg_state <= pstsel_pkg::PSTSEL_SEG_DONE;
      r.cmd.cw_addr <= pstsel_pkg::PSTSEL_CW_BASE;
      r.hreadyout <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register; hresp is tied to zero.
  assign hrdata = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp = 1'b0;
  assign seg_cmd = r.cmd;
  assign irq = r.irq;

endmodule

// [test/pstsel_monitor.sv]
/* Port checker of pstsel_top, attached by bind.
   Assumes hready is the slave's own hreadyout. */
`timescale 1ns/100ps
// ****************
// Port checker
// ****************
module pstsel_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic servo_en,
  input wire pstsel_pkg::pstsel_seg_cmd_t seg_cmd,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // A read waits exactly one cycle, a write none.
  a_read_one_wait: assert property (
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state wrong.");
  a_write_no_wait: assert property (
    hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("Write was stalled.");
  // Launch fields agree with the segment number.
  a_home_on_zero: assert property (
    seg_cmd.start |-> seg_cmd.home == (seg_cmd.number == 5'h00))
    else $error("Home flag wrong.");
  a_cw_addr_step: assert property (
    seg_cmd.start |-> seg_cmd.cw_addr == 16'h0804 + {9'h000, seg_cmd.number, 2'h0})
    else $error("Control word address wrong.");
  a_number_held: assert property (
    !seg_cmd.start |-> $stable(seg_cmd.number) && $stable(seg_cmd.cw_addr))
    else $error("Segment number moved without a launch.");
  // Nothing runs or stops with the servo off, and a stop never comes with a start.
  a_start_servo_on: assert property (
    seg_cmd.start |-> $past(servo_en))
    else $error("Launch with servo off.");
  a_stop_servo_on: assert property (
    seg_cmd.stop |-> $past(servo_en))
    else $error("Stop with servo off.");
  a_stop_beats_start: assert property (
    seg_cmd.stop |-> !seg_cmd.start)
    else $error("Launch together with stop.");
  cover property (seg_cmd.start && seg_cmd.home);
  cover property (seg_cmd.start && !seg_cmd.home);
  cover property (seg_cmd.stop);
  cover property ($rose(irq));
endmodule
bind pstsel_top pstsel_monitor mon (.clk(clk), .rstn(rstn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .servo_en(servo_en),
  .seg_cmd(seg_cmd), .irq(irq));

// [test/pstsel_ctl_model.sv]
/* Upper controller model driving the input terminals.
   Assumes terminal 0 triggers, 1 to 5 select, 6 stops. */
`timescale 1ns/100ps
// ****************
// Controller model
// ****************
module pstsel_ctl_model (
  input wire logic clk,
  output logic [7:0] term
);
  initial term = 8'h00;
  // Select first, then a wide trigger pulse; select then goes stale.
  task automatic run(input logic [4:0] n);
    @(posedge clk);
    term[5:1] <= n;
    repeat (2) @(posedge clk);
    term[0] <= 1'b1;
    repeat (3) @(posedge clk);
    term[0] <= 1'b0;
    @(posedge clk);
    term[5:1] <= ~n;
  endtask
  // A wide stop pulse.
  task automatic halt();
    @(posedge clk);
    term[6] <= 1'b1;
    repeat (3) @(posedge clk);
    term[6] <= 1'b0;
  endtask
endmodule

// [test/pstsel_bench.sv]
/* Self-checking bench of pstsel_top.
   Assumes the controller model and the port checker. */
`timescale 1ns/100ps
// ****************
// Bench
// ****************
module pstsel_bench;
  logic clk, rstn, hsel, hwrite, servo_en, seg_done, hreadyout, hresp, irq, prev_rdy;
  logic [31:0] haddr, hwdata, hrdata, ev_seen;
  logic [1:0] htrans;
  logic [7:0] term;
  logic [4:0] n;
  pstsel_pkg::pstsel_seg_cmd_t seg_cmd;
  logic [31:0] exp_ev[$];
  logic [31:0] exp_rd[$];
  int errors, cmp_count, seed, i;
  pstsel_top DUT (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .digital_input_terminal(term),
    .servo_en(servo_en), .seg_done(seg_done), .seg_cmd(seg_cmd), .irq(irq));
  pstsel_ctl_model ctl (.clk(clk), .term(term));
  // Free running clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wait_rdy;
    int k;
    k = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 20) begin
        errors++;
        wrap_up();
      end
      @(negedge clk);
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    wait_rdy();
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    @(posedge clk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task launch(input logic [4:0] s);
    exp_ev.push_back({26'h0, s == 5'h0, s});
  endtask
  task done_pulse;
    @(posedge clk);
    seg_done <= 1'b1;
    @(posedge clk);
    seg_done <= 1'b0;
  endtask
  // Results leave the queues in order as they show at the ports.
  always @(negedge clk) begin
    ev_seen = seg_cmd.stop ? 32'h100 : {26'h0, seg_cmd.home, seg_cmd.number};
    if (rstn && !prev_rdy && hreadyout) begin
      check(hrdata, exp_rd.pop_front());
      check({31'h0, hresp}, 32'h0);
    end
    if (seg_cmd.start || seg_cmd.stop)
      check(ev_seen, exp_ev.pop_front());
    prev_rdy <= hreadyout;
  end
  // A hang ends the run.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    seed = 35182;
    {errors, cmp_count} = 0;
    {rstn, hsel, hwrite, seg_done, prev_rdy, servo_en} = 6'h3;
    {haddr, hwdata, htrans} = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(12'h898, 32'h2710);
    rd(12'h920, 32'h0);
    rd(12'h800, 32'h0);
    for (i = 0; i < 7; i++)
      bus(1'b1, pstsel_pkg::PSTSEL_TERM_BASE_ADDR + 12'(4 * i),
        i == 6 ? 32'h20 : 32'h16 + i);
    rd(12'h92c, 32'h19);
    bus(1'b1, 12'h900, 32'h1);
    bus(1'b1, 12'h90c, 32'h1);
    $display("Test setup done");
    for (i = 0; i < 6; i++) begin
      n = i == 0 ? 5'h0 : i == 1 ? 5'h1f : 5'($random(seed));
      launch(n);
      ctl.run(n);
      rd(12'h898, 32'h2710 + n);
      done_pulse();
      rd(12'h898, 32'h4e20 + n);
      if (i == 0)
        check({31'h0, irq}, 32'h1);
      if (i == 0)
        bus(1'b1, 12'h90c, 32'h0);
      if (i == 0)
        bus(1'b1, 12'h910, 32'h1);
    end
    check({31'h0, irq}, 32'h0);
    bus(1'b1, 12'h90c, 32'h1);
    repeat (2) @(negedge clk);
    check({31'h0, irq}, 32'h1);
    $display("Test terminals done");
    for (i = 0; i < 3; i++) begin
      n = i == 0 ? 5'h1 : i == 1 ? 5'h1f : 5'($random(seed)) | 5'h1;
      launch(n);
      bus(1'b1, 12'h898, {27'h0, n});
      rd(12'h898, 32'h2710 + n);
      exp_ev.push_back(32'h100);
      bus(1'b1, 12'h898, 32'h3e8);
      rd(12'h898, 32'h4e20 + n);
    end
    bus(1'b1, 12'h910, 32'hf);
    bus(1'b1, 12'h898, 32'h0);
    bus(1'b1, 12'h898, 32'h20);
    bus(1'b1, 12'h898, 32'hffff);
    rd(12'h908, 32'h8);
    bus(1'b1, 12'h900, 32'h0);
    bus(1'b1, 12'h898, 32'h5);
    rd(12'h898, 32'h4e20 + n);
    rd(12'h908, 32'h8);
    $display("Test parameter done");
    launch(5'h7);
    ctl.run(5'h7);
    exp_ev.push_back(32'h100);
    ctl.halt();
    repeat (4) @(posedge clk);
    rd(12'h898, 32'h4e27);
    rd(12'h904, 32'h702);
    servo_en <= 1'b0;
    bus(1'b1, 12'h900, 32'h1);
    bus(1'b1, 12'h898, 32'h5);
    ctl.run(5'h3);
    repeat (4) @(posedge clk);
    rd(12'h898, 32'h4e20);
    repeat (4) @(posedge clk);
    check(32'(exp_ev.size() + exp_rd.size()), 32'h0);
    $display("Test stop and servo done");
    wrap_up();
  end
endmodule
